// ==== core/trpc_pkg.sv ====
// Package: register map, field layout and bus carriers of the trace readout block
//
// Overview of operation
// - Byte or misaligned data read returns zero
// - Armed data reads return zero, pointer held
// - Trace data register has no reset value
// - Full flag set after 64 stored words
// - Arm write clears the full flag
// - Six-bit count of valid stored words
// - Count wrap sets full; end mode continues
// - Arm write clears the count and full flag; status and mask bits kept
// - Full at zero, begin mode: disarm, break
// - Full with nonzero count means circular overwrite
// - Page selector upper bit ignored
// - Selector 01 matches extended bits to 21:16
// - Program page forms address bits 21:14
// - Comparator C paged match in breakpoint mode
// - Arm bit enables comparing and storing; the code gates storing only, COMPARE_C_MATCH does not depend on arm
// - Begin bit: trigger starts or ends storing
package trpc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] TRPC_OFS_DATA  = 4'h0;
    localparam logic [3:0] TRPC_OFS_COUNT = 4'h4;
    localparam logic [3:0] TRPC_OFS_CCX   = 4'h8;
    localparam logic [3:0] TRPC_OFS_CTRL  = 4'hc;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TRPC_CNT_FULL_BIT  = 7;
    localparam int TRPC_CCX_SEL_LO    = 6;
    localparam int TRPC_CTRL_ARM_BIT  = 6;
    localparam int TRPC_CTRL_BEGIN    = 4;
    localparam int TRPC_CTRL_BRK_BIT  = 3;
    localparam int TRPC_IRQ_FULL_BIT  = 0;
    localparam int TRPC_IRQ_DONE_BIT  = 1;
    localparam int TRPC_CCX_MASK_LO   = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TRPC_RST_CCX  = 8'h00;
    localparam logic [7:0] TRPC_RST_CTRL = 8'h00;
    localparam logic [5:0] TRPC_RST_CNT  = 6'h00;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } trpc_wb_req_s;

    // Paged address from the core
    typedef struct packed {
        logic [7:0]  page;
        logic [15:0] addr;
    } trpc_cpu_addr_s;

endpackage

// ==== core/trpc_top.sv ====
// Top module: trace buffer readout, word counter and comparator C page compare
`timescale 1ns/1ps
module trpc_top #(
    parameter int DEPTH = 64
) (
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        CAPTURE_VALID,
    input  wire logic [15:0] CAPTURE_WORD,
    input  wire logic [7:0]  PROGRAM_PAGE_VALUE,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic [15:0] COMPARE_C_ADDR,
    output logic             ARMED,
    output logic             BEGIN_TRIGGER,
    output logic      [1:0]  CAPTURE_MODE,
    output logic             BREAK_ON_COMPLETION_ENABLE,
    output logic             BREAK_REQUEST,
    output logic             COMPARE_C_MATCH,
    output logic             IRQ
);

    // ------------------------------------------------------------------
    // Elaboration check and local types
    // ------------------------------------------------------------------
    if (DEPTH != 64) begin : g_bad_depth
        $error("trpc_top: depth must be 64 to match the six-bit count");
    end

    trpc_pkg::trpc_wb_req_s   req;
    trpc_pkg::trpc_cpu_addr_s cpu;
    logic [15:0] mem [DEPTH];           // Trace memory, no reset
    logic [5:0]  wr_ptr_reg;
    logic [5:0]  rd_ptr_reg;
    logic [5:0]  valid_word_count_reg;
    logic        buffer_full_flag_reg;
    logic [7:0]  ccx_reg;
    logic [7:0]  ctrl_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        brk_reg;
    logic        access;
    logic        wr_ctrl;
    logic        arm_write;
    logic        store;
    logic        wrap;
    logic        complete;
    logic        word_rd;
    logic        data_rd;
    logic [5:0]  count_next;
    logic [31:0] rdata_next;
    logic        wr_ccx;
    logic        wr_mask;
    logic        stat_rd;
    logic [1:0]  irq_event;

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                   sel: WB_SEL_I, dat: WB_DAT_I};
    assign cpu = '{page: PROGRAM_PAGE_VALUE, addr: CPU_ADDR};

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One access per request, answered one cycle after it is seen
    assign access    = req.cyc && req.stb && !ack_reg;
    assign wr_ctrl   = access && req.we && req.adr == trpc_pkg::TRPC_OFS_CTRL
                       && req.sel[0];
    assign arm_write = wr_ctrl && req.dat[trpc_pkg::TRPC_CTRL_ARM_BIT];
    assign data_rd   = access && !req.we && req.adr == trpc_pkg::TRPC_OFS_DATA;
    // Only the low 16-bit half as a whole is a word access
    assign word_rd   = data_rd && req.sel == 4'h3;
    // Page extension in the low lane, interrupt mask in the next lane
    assign wr_ccx    = access && req.we && req.adr == trpc_pkg::TRPC_OFS_CCX && req.sel[0];
    assign wr_mask   = access && req.we && req.adr == trpc_pkg::TRPC_OFS_CCX && req.sel[1];
    // A read of the count word's top lane clears the sticky status
    assign stat_rd   = access && !req.we && req.adr == trpc_pkg::TRPC_OFS_COUNT && req.sel[3];

    // ------------------------------------------------------------------
    // Capture, count and full flag
    // ------------------------------------------------------------------
    assign store      = ctrl_reg[trpc_pkg::TRPC_CTRL_ARM_BIT] && CAPTURE_VALID;
    assign count_next = valid_word_count_reg + 6'h01;
    assign wrap       = store && valid_word_count_reg == 6'h3f;
    // Begin mode completes when the 64th word lands
    assign complete   = wrap && ctrl_reg[trpc_pkg::TRPC_CTRL_BEGIN];

    // Trace memory write; circular overwrite once full
    always_ff @(posedge MCLK) begin
        if (store) begin
            mem[wr_ptr_reg] <= CAPTURE_WORD;
        end
    end

    // Write pointer
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            wr_ptr_reg <= 6'h00;
        end else if (arm_write) begin
            wr_ptr_reg <= 6'h00;
        end else if (store) begin
            wr_ptr_reg <= wr_ptr_reg + 6'h01;
        end
    end

    // Word counter; cleared by an arm write
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            valid_word_count_reg <= trpc_pkg::TRPC_RST_CNT;
        end else if (arm_write) begin
            valid_word_count_reg <= trpc_pkg::TRPC_RST_CNT;
        end else if (store) begin
            valid_word_count_reg <= count_next;
        end
    end

    // Full flag: set on wrap, cleared by arm
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            buffer_full_flag_reg <= 1'b0;
        end else if (arm_write) begin
            buffer_full_flag_reg <= 1'b0;
        end else if (wrap) begin
            buffer_full_flag_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Readout pointer
    // ------------------------------------------------------------------
    // Oldest entry first once the buffer has wrapped
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rd_ptr_reg <= 6'h00;
        end else if (arm_write) begin
            rd_ptr_reg <= 6'h00;
        end else if (store && (wrap || buffer_full_flag_reg)) begin
            // Once full, every store overwrites the oldest entry
            rd_ptr_reg <= wr_ptr_reg + 6'h01;
        end else if (word_rd && !ctrl_reg[trpc_pkg::TRPC_CTRL_ARM_BIT]) begin
            rd_ptr_reg <= rd_ptr_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Control, page extension and interrupt registers
    // ------------------------------------------------------------------
    // Control: arm, begin, break enable, capture mode; arm self-clears on begin-mode completion
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg <= trpc_pkg::TRPC_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_reg <= req.dat[7:0];
        end else if (complete) begin
            ctrl_reg[trpc_pkg::TRPC_CTRL_ARM_BIT] <= 1'b0;
        end
    end

    // Page extension register
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ccx_reg <= trpc_pkg::TRPC_RST_CCX;
        end else if (wr_ccx) begin
            ccx_reg <= req.dat[7:0];
        end
    end

    // Break request pulse on completion
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            brk_reg <= 1'b0;
        end else begin
            brk_reg <= complete && ctrl_reg[trpc_pkg::TRPC_CTRL_BRK_BIT];
        end
    end

    // Events that set the sticky status bits
    always_comb begin
        irq_event = 2'h0;
        irq_event[trpc_pkg::TRPC_IRQ_FULL_BIT] = wrap;
        irq_event[trpc_pkg::TRPC_IRQ_DONE_BIT] = complete;
    end

    // Sticky status; a read clears it, a new event in the same cycle wins
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= (stat_rd ? 2'h0 : irq_stat_reg) | irq_event;
        end
    end

    // Mask register shares the status layout
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            irq_mask_reg <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_reg <= req.dat[trpc_pkg::TRPC_CCX_MASK_LO +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (req.adr)
            trpc_pkg::TRPC_OFS_DATA: begin
                if (word_rd && !ctrl_reg[trpc_pkg::TRPC_CTRL_ARM_BIT]) begin
                    rdata_next = {16'h0000, mem[rd_ptr_reg]};
                end
            end
            trpc_pkg::TRPC_OFS_COUNT: begin
                rdata_next = {irq_stat_reg, 6'h00, irq_mask_reg, 6'h00,
                              8'h00, buffer_full_flag_reg, 1'b0,
                              valid_word_count_reg};
            end
            trpc_pkg::TRPC_OFS_CCX: begin
                rdata_next = {22'h000000, irq_mask_reg, ccx_reg};
            end
            trpc_pkg::TRPC_OFS_CTRL: begin
                rdata_next = {24'h000000, ctrl_reg};
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Registered answer: ack one cycle after the request
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= access;
            rdata_reg <= access ? rdata_next : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Comparator C paged match
    // ------------------------------------------------------------------
    // Selector bit 7 is ignored; 01 adds the page compare
    always_comb begin
        if (ccx_reg[trpc_pkg::TRPC_CCX_SEL_LO]) begin
            COMPARE_C_MATCH = ccx_reg[5:0] == cpu.page[7:2]
                && {cpu.page[1:0], cpu.addr[13:0]} == COMPARE_C_ADDR;
        end else begin
            COMPARE_C_MATCH = cpu.addr == COMPARE_C_ADDR;
        end
    end

    assign WB_DAT_O                   = rdata_reg;
    assign WB_ACK_O                   = ack_reg;
    assign ARMED                      = ctrl_reg[trpc_pkg::TRPC_CTRL_ARM_BIT];
    assign BEGIN_TRIGGER              = ctrl_reg[trpc_pkg::TRPC_CTRL_BEGIN];
    assign CAPTURE_MODE               = ctrl_reg[1:0];
    assign BREAK_ON_COMPLETION_ENABLE = ctrl_reg[trpc_pkg::TRPC_CTRL_BRK_BIT];
    assign BREAK_REQUEST              = brk_reg;
    assign IRQ                        = |(irq_stat_reg & irq_mask_reg);

endmodule

// ==== verif/trpc_monitor.sv ====
// Checker: bus timing, read refusal and completion assertions of the trace block
`timescale 1ns/1ps
module trpc_monitor #(
    parameter int DEPTH = 64
) (
    input wire logic        MCLK,
    input wire logic        NRST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        ARMED,
    input wire logic        BEGIN_TRIGGER,
    input wire logic        BREAK_ON_COMPLETION_ENABLE,
    input wire logic        BREAK_REQUEST
);
    default clocking mon_cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // ----------------------------------------------------------------
    // Bus steps
    // ----------------------------------------------------------------
    sequence s_taken;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_data_rd;
        s_taken ##0 (!WB_WE_I && WB_ADR_I == 4'h0);
    endsequence
    sequence s_arm_wr;
        s_taken ##0 (WB_WE_I && WB_ADR_I == 4'hc && WB_SEL_I[0] && WB_DAT_I[6]);
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_ACK_NEXT: assert property (s_taken |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    AST_BYTE_ZERO: assert property (
        s_data_rd ##0 (WB_SEL_I != 4'h3) |=> WB_DAT_O == 32'h0)
        else $error("partial data read not zero");
    AST_ARMED_ZERO: assert property (s_data_rd ##0 ARMED |=> WB_DAT_O == 32'h0)
        else $error("armed data read not zero");
    AST_ARM_SET: assert property (s_arm_wr |-> ##[1:2] ARMED)
        else $error("arm write did not arm");
    AST_BRK_PULSE: assert property (BREAK_REQUEST |=> !BREAK_REQUEST)
        else $error("break request longer than one cycle");
    AST_BRK_COND: assert property (
        BREAK_REQUEST |-> BEGIN_TRIGGER && BREAK_ON_COMPLETION_ENABLE)
        else $error("break request without begin mode and enable");
    AST_BRK_DISARM: assert property (BREAK_REQUEST |-> ##[0:1] !ARMED)
        else $error("arm not cleared at completion");
endmodule

bind trpc_top trpc_monitor #(.DEPTH(DEPTH)) trpc_monitor_i (
    .MCLK(MCLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ARMED(ARMED), .BEGIN_TRIGGER(BEGIN_TRIGGER),
    .BREAK_ON_COMPLETION_ENABLE(BREAK_ON_COMPLETION_ENABLE), .BREAK_REQUEST(BREAK_REQUEST)
);

// ==== verif/tb.sv ====
// Testbench: register sequences against the trace readout block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic                  mclk;
    logic                  nrst;
    trpc_pkg::trpc_wb_req_s req;
    logic [31:0]           dat_o;
    logic                  ack, cap_v, armed, begin_t, brk_en, brk, match, irq;
    logic [15:0]           cap_w, cpu, cc;
    logic [7:0]            pp;
    logic [1:0]            capmode;
    int                    miscompares, tests_run, cycles, brk_cnt;
    logic [7:0]            ccx [6] = '{8'h45, 8'hc5, 8'h46, 8'h44, 8'h06, 8'h86};
    logic                  ccm [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1};

    trpc_top #(.DEPTH(64)) trpc_top_i (
        .MCLK(mclk), .NRST(nrst), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb), .WB_WE_I(req.we),
        .WB_ADR_I(req.adr), .WB_SEL_I(req.sel), .WB_DAT_I(req.dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .CAPTURE_VALID(cap_v), .CAPTURE_WORD(cap_w),
        .PROGRAM_PAGE_VALUE(pp), .CPU_ADDR(cpu), .COMPARE_C_ADDR(cc), .ARMED(armed),
        .BEGIN_TRIGGER(begin_t), .CAPTURE_MODE(capmode), .BREAK_ON_COMPLETION_ENABLE(brk_en),
        .BREAK_REQUEST(brk), .COMPARE_C_MATCH(match), .IRQ(irq)
    );

    // ----------------------------------------------------------------
    // Clock, watchdog and break pulse counter
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (brk === 1'h1) brk_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Bus and capture tasks
    // ----------------------------------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        req <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: s, dat: d};
        do begin
            @(posedge mclk);
        end while (ack !== 1'h1);
        q = dat_o;
        req.cyc <= 1'h0;
        req.stb <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, s, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [3:0] s, input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, a, s, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic capture(input int n, input logic [15:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            cap_v <= 1'h1;
            cap_w <= base + 16'(i);
        end
        @(posedge mclk);
        cap_v <= 1'h0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'h0; req = '0; cap_v = 1'h0; cap_w = 16'h0;
        pp = 8'h16; cpu = 16'h9234; cc = 16'h9234;
        repeat (5) @(posedge mclk);
        nrst <= 1'h1;
        rd(4'h4, 4'hf, 32'h0); rd(4'h8, 4'hf, 32'h0); rd(4'hc, 4'hf, 32'h0);
        wr(4'h6, 4'hf, 32'hffff_ffff);
        rd(4'h6, 4'hf, 32'h0);
        $display("reset and unmapped test done");
        for (int m = 0; m < 4; m++) begin
            wr(4'hc, 4'h1, 32'h18 | m);
            `CHK({begin_t, brk_en, capmode}, {2'h3, 2'(m)})
            rd(4'hc, 4'h1, 32'h18 | m);
        end
        $display("control test done");
        wr(4'hc, 4'h1, 32'h48); capture(3, 16'ha000);
        rd(4'h4, 4'hf, 32'h3);
        rd(4'h0, 4'h3, 32'h0);
        wr(4'hc, 4'h1, 32'h0);
        rd(4'h0, 4'h3, 32'ha000);
        rd(4'h0, 4'h1, 32'h0); rd(4'h2, 4'h3, 32'h0);
        rd(4'h0, 4'h3, 32'ha001);
        $display("readout test done");
        wr(4'hc, 4'h1, 32'h40); capture(66, 16'h0100);
        `CHK(irq, 1'h0)
        wr(4'h8, 4'h2, 32'h100);
        `CHK(irq, 1'h1)
        rd(4'h4, 4'hf, 32'h4040_0082);
        `CHK(irq, 1'h0)
        wr(4'hc, 4'h1, 32'h0);
        rd(4'h0, 4'h3, 32'h0102);
        rd(4'h0, 4'h3, 32'h0103);
        wr(4'hc, 4'h1, 32'h40);
        rd(4'h4, 4'hf, 32'h0040_0000);
        wr(4'h8, 4'h2, 32'h0);
        `CHK(irq, 1'h0)
        $display("wrap and interrupt test done");
        brk_cnt = 0;
        wr(4'hc, 4'h1, 32'h58); capture(65, 16'h0200);
        `CHK({armed, brk_cnt}, {1'h0, 32'h1})
        rd(4'h4, 4'hf, 32'hc000_0080);
        $display("begin mode test done");
        for (int k = 0; k < 6; k++) begin
            wr(4'h8, 4'h1, {24'h0, ccx[k]});
            rd(4'h8, 4'h1, {24'h0, ccx[k]});
            `CHK(match, ccm[k])
        end
        $display("page compare test done");
        complete_run();
    end
endmodule
